/* File: rtl/mcg_cfg.svh */
// Purpose: constants for the master clock generator
// Assumes: 32-bit APB, one word per register
// Notes: definitions only
`ifndef MCG_CFG_SVH
`define MCG_CFG_SVH

// apb map
`define MCG_AW        12
`define MCG_OFF_LOOP  12'h000
`define MCG_OFF_SYS1  12'h004
`define MCG_OFF_STAT  12'h008

// loop config word fields
`define MCG_F_SRC     1:0
`define MCG_F_VBAND   5:4
`define MCG_F_IDIV    9:8
`define MCG_F_ODIV    15:12
`define MCG_F_MUL     20:16
// system config one field
`define MCG_F_HALVE   0
// status word fields
`define MCG_F_PLLACT  0
`define MCG_F_LOCKED  1
`define MCG_F_HALVEAC 2
`define MCG_F_PEND    3
`define MCG_F_STEP    31:16

// field widths and limits
`define MCG_IDIV_W    2
`define MCG_ODIV_W    4
`define MCG_MUL_W     5
`define MCG_IDIV_MAX  2'h3
`define MCG_ODIV_MAX  4'he
`define MCG_SRC_PLL   2'h3
`define MCG_VB_RSVD   2'h3
`define MCG_VB_0      2'h0
`define MCG_VB_1      2'h1

// reset values
`define MCG_SRC_RST   2'h0
`define MCG_VB_RST    2'h0
`define MCG_IDIV_RST  2'h0
`define MCG_ODIV_RST  4'h0
`define MCG_MUL_RST   5'h00
`define MCG_HALVE_RST 1'b0

// digital vco model
`define MCG_CNT_W     6
`define MCG_VH_W      8
`define MCG_STEP_W    16
`define MCG_STEP_MIN  16'h0001
`define MCG_STEP_MAX  16'h8000
`define MCG_STEP_B0   16'h1000
`define MCG_STEP_B1   16'h1800
`define MCG_STEP_B2   16'h2000

`endif

/* File: rtl/mcg_master_clock_gen.sv */
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
// Purpose: master, cpu and system clock generation from the oscillator
// Assumes: oscillator input is slow against clk; clocks are made as
//          registered waveforms sampled on clk
// Notes: the vco is a phase accumulator steered by a frequency loop
`include "mcg_cfg.svh"

// What this block does
// - source select upper bit clear: bypass through both prescalers
// - bypass master rate is oscillator over (idiv+1) times (odiv+1)
// - input divider tops at 3, output divider tops at 14
// - both dividers zero in bypass: master follows oscillator edges and duty
// - source select 11 enables the loop, which supplies master
// - loop master is oscillator times (mul+1) over both divider terms
// - loop frequency is adjusted gradually, never abruptly
// - vco output divided by odiv plus one gives master clock
// - cpu clock is master clock, or half of it when halving set
// - core and external bus controller both run on cpu clock
// - system clock always runs at cpu clock frequency
// - vco band 00, 01, 10 select bands; 11 is reserved
module mcg_master_clock_gen (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // oscillator pin
    input  wire logic                  oscillatorInput,
    // apb slave
    input  wire mcg_pkg::mcg_apb_req_s apbReq,
    output      mcg_pkg::mcg_apb_rsp_s apbRsp,
    // generated clocks
    output      logic                  masterClk,
    output      logic                  cpuClk,
    output      logic                  busCtrlClk,
    output      logic                  sysClk
);
    import mcg_pkg::*;

    mcg_cfg_s                  cfg_q;
    mcg_cfg_s                  cfgD;
    mcg_cfg_s                  act_q;
    logic                      halve_q;
    logic                      halveAct_q;
    logic [2:0]                osc_q;
    logic [`MCG_CNT_W-1:0]     cnt_q;
    logic                      mclk_q;
    logic                      cpu_q;
    logic                      cpuD;
    logic                      ebc_q;
    logic                      sys_q;
    logic [`MCG_STEP_W-1:0]    acc_q;
    logic [`MCG_STEP_W-1:0]    step_q;
    logic [`MCG_STEP_W-1:0]    stepD;
    logic [`MCG_STEP_W-1:0]    stepInit;
    logic [`MCG_STEP_W:0]      accSum;
    logic [`MCG_VH_W-1:0]      vh_q;
    logic [`MCG_VH_W-1:0]      vhInc;
    logic [`MCG_VH_W-1:0]      target;
    logic [`MCG_IDIV_W-1:0]    rise_q;
    logic                      arm_q;
    logic                      locked_q;
    logic [31:0]               rdat_q;
    logic [31:0]               cfgWord;
    logic [31:0]               statWord;
    mcg_mode_e                 actMode;

    // oscillator pin sync; stage 0 feeds only stage 1
    wire oscEdge = osc_q[1] ^ osc_q[2];
    wire oscRise = osc_q[1] & ~osc_q[2];
    wire oscFall = ~osc_q[1] & osc_q[2];

    // apb decode
    wire setup   = apbReq.psel & ~apbReq.penable;
    wire access  = apbReq.psel & apbReq.penable;
    wire hitLoop = apbReq.paddr == `MCG_OFF_LOOP;
    wire hitSys  = apbReq.paddr == `MCG_OFF_SYS1;
    wire hitStat = apbReq.paddr == `MCG_OFF_STAT;
    wire hitAny  = hitLoop | hitSys | hitStat;
    wire wrLoop  = access & apbReq.pwrite & hitLoop;
    wire wrSys   = access & apbReq.pwrite & hitSys;
    wire [31:0] rdNext = hitLoop ? cfgWord :
                         hitSys  ? {31'h0, halve_q} :
                         hitStat ? statWord : 32'h0;

    // answer: no wait states, unmapped address flags an error
    assign apbRsp.pready  = 1'b1;
    assign apbRsp.pslverr = access & ~hitAny;
    assign apbRsp.prdata  = rdat_q;

    // source in force; an upper bit set without 11 stays bypass
    assign actMode = (act_q.src == `MCG_SRC_PLL) ? MODE_PLL
                                                 : MODE_BYPASS;
    wire pllAct  = actMode == MODE_PLL;
    wire pending = cfg_q != act_q;

    // divider selection
    wire [`MCG_CNT_W-1:0] byN = `MCG_CNT_W'(
        ({4'h0, act_q.idiv} + 6'h1) * ({2'h0, act_q.odiv} + 6'h1));
    wire [`MCG_CNT_W-1:0] kDiv = {2'h0, act_q.odiv} + 6'h1;
    wire [`MCG_CNT_W-1:0] divN = pllAct ? kDiv : byN;

    // half-period events: oscillator edges or vco half cycles
    assign accSum = {1'b0, acc_q} + {1'b0, step_q};
    wire vcoHalf = pllAct & accSum[`MCG_STEP_W];
    // after a move to bypass, wait for a pin fall: no short first phase
    wire srcTick = pllAct ? vcoHalf : oscEdge & ~arm_q;
    wire toggle  = srcTick & (cnt_q == divN - 6'h1);
    wire mRise   = toggle & ~mclk_q;
    wire mFall   = toggle & mclk_q;
    // new settings land only as master falls, so no runt high phase
    wire adopt   = mFall & pending;
    wire hvAdopt = mRise & ~cpu_q;

    // frequency loop window spans idiv+1 oscillator periods
    wire winEnd = pllAct & oscRise & (rise_q == act_q.idiv);
    assign target = `MCG_VH_W'({act_q.mul, 1'b0}) + 8'h2;
    assign vhInc  = (vh_q == {`MCG_VH_W{1'b1}}) ? vh_q
                                               : vh_q + `MCG_VH_W'(vcoHalf);
    assign stepInit = (cfg_q.vband == `MCG_VB_0) ? `MCG_STEP_B0 :
                      (cfg_q.vband == `MCG_VB_1) ? `MCG_STEP_B1
                                                 : `MCG_STEP_B2;

    // step moves one unit per window at most: no abrupt jumps
    always_comb begin
        stepD = step_q;
        if (!pllAct) begin
            stepD = stepInit;
        end else if (winEnd && vhInc < target
                     && step_q < `MCG_STEP_MAX) begin
            stepD = step_q + 16'h1;
        end else if (winEnd && vhInc > target
                     && step_q > `MCG_STEP_MIN) begin
            stepD = step_q - 16'h1;
        end
    end

    // register write with clamp and reserved band refusal
    always_comb begin
        cfgD = cfg_q;
        if (wrLoop) begin
            cfgD.src  = apbReq.pwdata[`MCG_F_SRC];
            cfgD.idiv = apbReq.pwdata[`MCG_F_IDIV];
            cfgD.mul  = apbReq.pwdata[`MCG_F_MUL];
            if (apbReq.pwdata[`MCG_F_ODIV] > `MCG_ODIV_MAX) begin
                cfgD.odiv = `MCG_ODIV_MAX;
            end else begin
                cfgD.odiv = apbReq.pwdata[`MCG_F_ODIV];
            end
            if (apbReq.pwdata[`MCG_F_VBAND] != `MCG_VB_RSVD) begin
                cfgD.vband = apbReq.pwdata[`MCG_F_VBAND];
            end
        end
    end

    // cpu clock: master, or toggled on each master rise when halved
    always_comb begin
        cpuD = cpu_q;
        if (mRise) begin
            cpuD = ~cpu_q;
        end else if (mFall && !halveAct_q) begin
            cpuD = 1'b0;
        end
    end

    // read words
    always_comb begin
        cfgWord = 32'h0;
        cfgWord[`MCG_F_SRC]   = cfg_q.src;
        cfgWord[`MCG_F_VBAND] = cfg_q.vband;
        cfgWord[`MCG_F_IDIV]  = cfg_q.idiv;
        cfgWord[`MCG_F_ODIV]  = cfg_q.odiv;
        cfgWord[`MCG_F_MUL]   = cfg_q.mul;
        statWord = 32'h0;
        statWord[`MCG_F_PLLACT]  = pllAct;
        statWord[`MCG_F_LOCKED]  = locked_q;
        statWord[`MCG_F_HALVEAC] = halveAct_q;
        statWord[`MCG_F_PEND]    = pending;
        statWord[`MCG_F_STEP]    = step_q;
    end

    // registers and read capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q   <= CFG_RST;
            halve_q <= `MCG_HALVE_RST;
            rdat_q  <= 32'h0;
        end else begin
            cfg_q   <= cfgD;
            halve_q <= wrSys ? apbReq.pwdata[`MCG_F_HALVE] : halve_q;
            rdat_q  <= setup ? rdNext : rdat_q;
        end
    end

    // master clock divider and settings in force
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_q  <= 3'h0;
            arm_q  <= 1'b0;
            act_q  <= CFG_RST;
            cnt_q  <= '0;
            mclk_q <= 1'b0;
        end else begin
            osc_q  <= {osc_q[1:0], oscillatorInput};
            arm_q  <= (adopt & (cfg_q.src != `MCG_SRC_PLL))
                      | (arm_q & ~oscFall);
            act_q  <= adopt ? cfg_q : act_q;
            cnt_q  <= toggle  ? '0 :
                      srcTick ? cnt_q + 6'h1 : cnt_q;
            mclk_q <= toggle ? ~mclk_q : mclk_q;
        end
    end

    // vco accumulator and frequency loop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q    <= '0;
            step_q   <= `MCG_STEP_B0;
            vh_q     <= '0;
            rise_q   <= '0;
            locked_q <= 1'b0;
        end else begin
            acc_q    <= pllAct ? accSum[`MCG_STEP_W-1:0] : '0;
            step_q   <= stepD;
            vh_q     <= (!pllAct || winEnd) ? '0 : vhInc;
            rise_q   <= !pllAct ? '0 :
                        winEnd  ? '0 :
                        oscRise ? rise_q + 2'h1 : rise_q;
            locked_q <= pllAct & (winEnd ? vhInc == target
                                         : locked_q);
        end
    end

    // cpu, bus controller and system clocks share one next value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halveAct_q <= `MCG_HALVE_RST;
            cpu_q      <= 1'b0;
            ebc_q      <= 1'b0;
            sys_q      <= 1'b0;
        end else begin
            halveAct_q <= hvAdopt ? halve_q : halveAct_q;
            cpu_q      <= cpuD;
            ebc_q      <= cpuD;
            sys_q      <= cpuD;
        end
    end

    assign masterClk  = mclk_q;
    assign cpuClk     = cpu_q;
    assign busCtrlClk = ebc_q;
    assign sysClk     = sys_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_byp_src;
        $changed(mclk_q) && !$past(pllAct) |-> $past(oscEdge);
    endproperty
    a_byp_src: assert property (p_byp_src)
        else $error("bypass master moved without oscillator edge");

    property p_byp_div;
        $changed(mclk_q) && !$past(pllAct)
            |-> $past(cnt_q) == $past(byN) - 6'h1;
    endproperty
    a_byp_div: assert property (p_byp_div)
        else $error("bypass half period not idiv and odiv product");

    property p_div_max;
        cfg_q.odiv <= `MCG_ODIV_MAX && cfg_q.idiv <= `MCG_IDIV_MAX;
    endproperty
    a_div_max: assert property (p_div_max)
        else $error("divider field above its maximum");

    property p_follow;
        !pllAct && !arm_q && act_q.idiv == 2'h0 && act_q.odiv == 4'h0
            && oscEdge |=> $changed(mclk_q);
    endproperty
    a_follow: assert property (p_follow)
        else $error("undivided master missed an oscillator edge");

    property p_pll_on;
        $rose(pllAct) |-> $past(cfg_q.src) == `MCG_SRC_PLL && !mclk_q;
    endproperty
    a_pll_on: assert property (p_pll_on)
        else $error("loop enabled without select 11");

    property p_lock;
        $rose(locked_q) |-> $past(vhInc) == $past(target);
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock without matching vco count");

    property p_smooth;
        pllAct && $past(pllAct) |-> step_q == $past(step_q)
            || (step_q - $past(step_q) == 16'h1 && $past(winEnd))
            || ($past(step_q) - step_q == 16'h1 && $past(winEnd));
    endproperty
    a_smooth: assert property (p_smooth)
        else $error("vco step changed abruptly");

    property p_pll_div;
        $changed(mclk_q) && $past(pllAct)
            |-> $past(vcoHalf) && $past(cnt_q) == $past(kDiv) - 6'h1;
    endproperty
    a_pll_div: assert property (p_pll_div)
        else $error("loop master not vco over odiv plus one");

    property p_cpu;
        $changed(cpu_q)
            |-> $past(mRise) || ($past(mFall) && !$past(halveAct_q));
    endproperty
    a_cpu: assert property (p_cpu)
        else $error("cpu clock moved off a master edge");

    property p_ebc;
        $changed(cpu_q) |-> ebc_q == cpu_q ##1 ebc_q == cpu_q;
    endproperty
    a_ebc: assert property (p_ebc)
        else $error("bus controller clock differs from cpu clock");

    property p_sys;
        $changed(sys_q) |-> $changed(cpu_q) && sys_q == cpu_q;
    endproperty
    a_sys: assert property (p_sys)
        else $error("system clock not in step with cpu clock");

    property p_band;
        cfg_q.vband != `MCG_VB_RSVD;
    endproperty
    a_band: assert property (p_band)
        else $error("reserved vco band stored");

    property p_switch;
        $changed(act_q) |-> $fell(mclk_q);
    endproperty
    a_switch: assert property (p_switch)
        else $error("source settings changed outside master fall");

    property p_halve_sw;
        $changed(halveAct_q) |-> $rose(mclk_q) && $rose(cpu_q);
    endproperty
    a_halve_sw: assert property (p_halve_sw)
        else $error("halving changed outside a cpu rising edge");

endmodule

/* File: rtl/mcg_pkg.sv */
// Purpose: shared types of the master clock generator
// Assumes: mcg_cfg.svh supplies widths and reset values
// Notes: apb request and answer travel as structs
`include "mcg_cfg.svh"
package mcg_pkg;

    // which source drives the master clock
    typedef enum logic {
        MODE_BYPASS = 1'b0,
        MODE_PLL    = 1'b1
    } mcg_mode_e;

    // loop configuration settings
    typedef struct packed {
        logic [`MCG_MUL_W-1:0]  mul;
        logic [`MCG_ODIV_W-1:0] odiv;
        logic [`MCG_IDIV_W-1:0] idiv;
        logic [1:0]             vband;
        logic [1:0]             src;
    } mcg_cfg_s;

    localparam mcg_cfg_s CFG_RST = '{
        mul:   `MCG_MUL_RST,
        odiv:  `MCG_ODIV_RST,
        idiv:  `MCG_IDIV_RST,
        vband: `MCG_VB_RST,
        src:   `MCG_SRC_RST
    };

    // apb request from the master
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [`MCG_AW-1:0] paddr;
        logic [31:0]       pwdata;
    } mcg_apb_req_s;

    // apb answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } mcg_apb_rsp_s;

endpackage

/* File: sim/mcg_osc_model.sv */
// Purpose: oscillator pin model feeding the master clock generator
// Assumes: high and low times are given in clk cycles
// Notes: zero in either time stops the pin, as a dead oscillator would
`timescale 1ns/1ps
module mcg_osc_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // waveform shape
    input  wire logic [7:0] highCyc,
    input  wire logic [7:0] lowCyc,
    // oscillator pin
    output logic            oscOut
);
    logic [7:0] cnt_q;

    // count out each phase; >= lets a shorter phase end at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 8'h01;
            oscOut <= 1'b0;
        end else if (highCyc != 8'h00 && lowCyc != 8'h00) begin
            if (cnt_q >= (oscOut ? highCyc : lowCyc)) begin
                cnt_q  <= 8'h01;
                oscOut <= !oscOut;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

/* File: sim/tb_master_clock_generation.sv */
// Purpose: self-checking bench for the master clock generator
// Assumes: apb slave answers with no wait states, clocks are registered
// Notes: periods are measured in clk cycles by a monitor process
`timescale 1ns/1ps
module tb_master_clock_generation;
    import mcg_pkg::*;
    logic         clk, rst_n, osc, masterClk, cpuClk, busCtrlClk, sysClk;
    logic [7:0]   oscHi, oscLo;
    mcg_apb_req_s req;
    mcg_apb_rsp_s rsp;
    logic         mPrev, cPrev, err;
    logic         sysBad = 1'b0;
    logic [31:0]  rd, w, exp;
    int num_errors, n_tests, cyc, mCnt, mPer, mRises, cCnt, cPer, cRises;
    int mHigh, mRun, cRun, i, n, t0, d, tol, idv, odv;
    int minRun = 999;
    int pOsc[3] = '{8, 16, 16};
    int pMul[3] = '{0, 2, 0};
    int pId[3]  = '{0, 1, 0};
    int pOd[3]  = '{1, 0, 2};
    int pVb[3]  = '{2, 1, 0};

    mcg_master_clock_gen dut_u (
        .clk(clk), .rst_n(rst_n), .oscillatorInput(osc),
        .apbReq(req), .apbRsp(rsp), .masterClk(masterClk),
        .cpuClk(cpuClk), .busCtrlClk(busCtrlClk), .sysClk(sysClk));
    mcg_osc_model osc_u (.clk(clk), .rst_n(rst_n), .highCyc(oscHi),
        .lowCyc(oscLo), .oscOut(osc));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, want);
        end
    endtask

    // periods, high time and shortest run; first run after reset ignored
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            num_errors = num_errors + 1;
            print_verdict();
        end
        if (!rst_n) begin
            mRun  <= -999;
            cRun  <= -999;
            mPrev <= 1'b0;
            cPrev <= 1'b0;
        end else begin
            mPrev <= masterClk;
            cPrev <= cpuClk;
            mRun  <= (masterClk !== mPrev) ? 1 : mRun + 1;
            cRun  <= (cpuClk !== cPrev) ? 1 : cRun + 1;
            // negative runs are the partial first run after reset
            if (masterClk !== mPrev && mRun > 0 && mRun < minRun) begin
                minRun <= mRun;
            end
            if (cpuClk !== cPrev && cRun > 0 && cRun < minRun) begin
                minRun <= cRun;
            end
            if (!masterClk && mPrev) mHigh <= mRun;
            mCnt <= (masterClk && !mPrev) ? 0 : mCnt + 1;
            cCnt <= (cpuClk && !cPrev) ? 0 : cCnt + 1;
            if (masterClk && !mPrev) mPer <= mCnt + 1;
            if (masterClk && !mPrev) mRises <= mRises + 1;
            if (cpuClk && !cPrev) cPer <= cCnt + 1;
            if (cpuClk && !cPrev) cRises <= cRises + 1;
            if (busCtrlClk !== cpuClk || sysClk !== cpuClk) sysBad <= 1'b1;
        end
    end

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= wd;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wait_rises(input bit cpu, input int k);
        int s;
        s = cpu ? cRises : mRises;
        while ((cpu ? cRises : mRises) < s + k) @(posedge clk);
    endtask

    function automatic logic [31:0] cfg(input int src, vb, id, od, mul);
        cfg = (mul << 16) | (od << 12) | (id << 8) | (vb << 4) | src;
    endfunction

    initial begin
        rst_n = 1'b0;
        req = '0;
        oscHi = 8'h04;
        oscLo = 8'h05;
        void'($urandom(32'hc0b0));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0);
        $display("test reset values done");
        // random settings; source bit 1 kept clear so the loop stays off
        exp = 32'h0;
        for (i = 0; i < 12; i++) begin
            w = $urandom & 32'h001ff331;
            if (i == 0) w[15:12] = 4'hf;
            if (i == 1) w[5:4] = 2'h3;
            apb(1'b1, 12'h000, w);
            if (w[15:12] == 4'hf) w[15:12] = 4'he;
            if (w[5:4] == 2'h3) w[5:4] = exp[5:4];
            exp = w;
            apb(1'b0, 12'h000, 32'h0);
            check(rd, exp);
        end
        apb(1'b1, 12'h00c, 32'hffffffff);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        check(rd, 32'h0);
        $display("test register access done");
        // bypass dividers: corners first, then random
        for (i = 0; i < 5; i++) begin
            idv = (i == 0) ? 0 : (i == 1) ? 3 : $urandom_range(3);
            odv = (i == 0) ? 0 : (i == 1) ? 14 : $urandom_range(14);
            apb(1'b1, 12'h000, cfg(i % 2, 0, idv, odv, 0));
            wait_rises(1'b0, 3);
            check(mPer, 9 * (idv + 1) * (odv + 1));
            check(cPer, mPer);
            if (i == 0) check(mHigh, 4);
        end
        $display("test bypass done");
        apb(1'b1, 12'h004, 32'h1);
        wait_rises(1'b1, 3);
        check(cPer, 2 * mPer);
        apb(1'b0, 12'h008, 32'h0);
        check(rd[2], 1'b1);
        apb(1'b1, 12'h004, 32'h0);
        wait_rises(1'b1, 3);
        check(cPer, mPer);
        $display("test cpu halving done");
        // loop mode, one case per band, start step matched to target
        for (i = 0; i < 3; i++) begin
            // back through bypass so the loop restarts from its band step
            apb(1'b1, 12'h000, cfg(0, pVb[i], 0, 0, 0));
            wait_rises(1'b0, 2);
            oscHi <= pOsc[i];
            oscLo <= pOsc[i];
            apb(1'b1, 12'h000, cfg(3, pVb[i], pId[i], pOd[i], pMul[i]));
            wait_rises(1'b0, 4);
            n = 0;
            do begin
                apb(1'b0, 12'h008, 32'h0);
                n++;
            end while (rd[1] !== 1'b1 && n < 400);
            check(rd[1:0], 2'h3);
            wait_rises(1'b0, 1);
            t0 = cyc;
            wait_rises(1'b0, 8);
            tol = 2 * pOsc[i] * (pId[i] + 1) * (pOd[i] + 1);
            d = (cyc - t0) * (pMul[i] + 1) - 8 * tol;
            check(d <= tol && d >= -tol, 1'b1);
        end
        $display("test loop mode done");
        oscHi <= 8'h04;
        oscLo <= 8'h05;
        apb(1'b1, 12'h000, cfg(0, 0, 0, 0, 0));
        wait_rises(1'b0, 4);
        check(mPer, 9);
        check(minRun >= 4, 1'b1);
        check(sysBad, 1'b0);
        $display("test switch back done");
        print_verdict();
    end
endmodule
